// ---- pkg/prog_debug_defs.svh ----
// Register offsets, field positions and reset values of the access layer bank
`ifndef PROG_DEBUG_DEFS_SVH
`define PROG_DEBUG_DEFS_SVH
`define ADDR_RESET_REQ 8'h08
`define ADDR_CLK_CTRL 8'h09
`define ADDR_SYS_CTRL 8'h0a
`define ADDR_SYS_STATUS 8'h0b
`define ADDR_SCAN_STATUS 8'h0c
`define ADDR_KEY_STATUS 8'h07
`define RESET_SIGNATURE 8'h59
`define CLKSEL_RESET 2'h3
`define CLKSEL_16MHZ 2'h1
`define CLKSEL_8MHZ 2'h2
`define CLKSEL_4MHZ 2'h3
`define CLKSEL_RESERVED 2'h0
`define CTRL_RESET 8'h02
`define STATUS_RESET 8'h01
`define BIT_SYSTEM_CLOCK_REQUEST 0
`define BIT_COMMIT 1
`define BIT_LOCKED 0
`define BIT_UROW_READY 2
`define BIT_PROG_READY 3
`define BIT_ASLEEP 4
`define BIT_RST_ACTIVE 5
`define BIT_KEY_ERASE 3
`define BIT_KEY_NVM 4
`define BIT_KEY_UROW 5
`define BIT_RST_HELD 0
`define CLKSEL_MSB 1
`define SCAN_MSB 2
`define KEY_COUNT 2
`define KEY_NVM_SLOT 1
`define KEY_ERASE_SLOT 0
`define SCAN_OFF 3'h0
`define SCAN_BUSY 3'h1
`define SCAN_PASS 3'h2
`define SCAN_FAIL 3'h4
`define BYTE_ZERO 8'h00
`endif

// ---- pkg/prog_debug_pkg.sv ----
// Types shared by the access layer register bank
package prog_debug_pkg;
    typedef enum logic [1:0] {
        CLK_RESERVED = 2'b00,
        CLK_16MHZ = 2'b01,
        CLK_8MHZ = 2'b10,
        CLK_4MHZ = 2'b11
    } clk_sel_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic nvm_key;
        logic erase_key;
        logic urow_key;
        logic nvm_done;
        logic erase_done;
        logic sys_in_reset;
        logic sys_asleep;
        logic prog_ready;
        logic urow_ready;
        logic locked;
        logic [2:0] scan_state;
    } sys_state_s;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
        logic sys_reset_req;
        logic clk_request;
        logic urow_commit;
        clk_sel_e clk_sel;
        logic nvm_key_flag;
        logic erase_key_flag;
        logic rst_seen;
        logic [1:0] port_en_d;
    } bank_s;
endpackage : prog_debug_pkg

// ---- rtl/prog_debug_access_regs.sv ----
// Access layer register bank of the single-pin program and debug port
// Notes on behaviour
// RULE1: Nvm program key flag reads 1 while key active, clears when programming done.
// RULE2: Full erase key flag reads 1 while key active, clears when erase completes.
// RULE3: Writing signature 0x59 to reset request holds system reset until released.
// RULE4: Writing any other value to reset request releases the held system reset.
// RULE5: Reset request reads 1 in bit 0 while reset held, other bits zero.
// RULE6: Issuing the system reset never resets this port's own logic.
// RULE7: Clock select: 1=16 MHz, 2=8 MHz, 3=4 MHz, 0 reserved; default 4 MHz.
// RULE8: Debugger should pick faster clocks only with highest brown-out level.
// RULE9: Writing user row commit starts programming user row from RAM to flash.
// RULE10: User row commit writes are accepted only when the user row key is active.
// RULE11: Commit before data placed lets the processor continue without that data.
// RULE12: Clock request bit 1 requests system clock despite sleep; 0 withdraws it.
// RULE13: Clock request clears when port disabled and sets whenever port enabled.
// RULE14: Reset active bit reads 1 during system reset, including held one; clears on read.
// RULE15: Asleep bit reads 1 while system idles or sleeps deeper, 0 when awake.
// RULE16: Programming ready bit shows nvm programming may begin from the port.
// RULE17: User row ready bit shows user row programming may begin.
// RULE18: Locked bit reads 1 while locked, 0 after erase clears lock bits.
// RULE19: Scan status is one-hot: 0 off, 1 busy, 2 pass, 4 fail.
// RULE20: Registers are reached only through the debug link access port.
// RULE21: Read-only and unused bits ignore writes; unused bits read zero.
`timescale 1ns/1ps
`include "prog_debug_defs.svh"
module prog_debug_access_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic port_enable,
    input prog_debug_pkg::reg_req_s req,
    input prog_debug_pkg::sys_state_s sys,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic sys_reset_req,
    output logic clk_request,
    output logic urow_commit,
    output prog_debug_pkg::clk_sel_e clk_sel
);
    import prog_debug_pkg::*;

    bank_s state_ff;
    bank_s nxt_state;
    logic [7:0] rd_mux;
    logic port_enable_rise;
    logic [`KEY_COUNT-1:0] key_live;
    logic [`KEY_COUNT-1:0] key_over;
    logic [`KEY_COUNT-1:0] key_flag_nxt;
    logic status_read;
    logic commit_write;
    logic port_steady;

    // Port reset values; clock select rests at 4 MHz
    localparam bank_s BANK_RESET = '{
        rdata: `BYTE_ZERO,
        rvalid: 1'b0,
        sys_reset_req: 1'b0,
        clk_request: 1'b0,
        urow_commit: 1'b0,
        clk_sel: clk_sel_e'(`CLKSEL_RESET),
        nvm_key_flag: 1'b0,
        erase_key_flag: 1'b0,
        rst_seen: 1'b0,
        port_en_d: 2'b00
    };

    // Write strobe aimed at one address
    function automatic logic wr_hit(input reg_req_s r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : wr_hit

    // Read strobe aimed at one address
    function automatic logic rd_hit(input reg_req_s r, input logic [7:0] a);
        return r.rd && (r.addr == a);
    endfunction : rd_hit

    // Read decode for one address
    function automatic logic [7:0] read_byte(input logic [7:0] a, input bank_s s,
                                              input sys_state_s y);
        logic [7:0] v;
        v = `BYTE_ZERO;
        case (a)
            `ADDR_KEY_STATUS: begin
                v[`BIT_KEY_NVM] = s.nvm_key_flag;
                v[`BIT_KEY_ERASE] = s.erase_key_flag;
                v[`BIT_KEY_UROW] = y.urow_key;
            end
            `ADDR_RESET_REQ: v[`BIT_RST_HELD] = s.sys_reset_req;
            `ADDR_CLK_CTRL: v[`CLKSEL_MSB:0] = s.clk_sel;
            `ADDR_SYS_CTRL: begin
                v[`BIT_SYSTEM_CLOCK_REQUEST] = s.clk_request;
                v[`BIT_COMMIT] = s.urow_commit;
            end
            `ADDR_SYS_STATUS: begin
                v[`BIT_RST_ACTIVE] = s.rst_seen;
                v[`BIT_ASLEEP] = y.sys_asleep;
                v[`BIT_PROG_READY] = y.prog_ready;
                v[`BIT_UROW_READY] = y.urow_ready;
                v[`BIT_LOCKED] = y.locked;
            end
            `ADDR_SCAN_STATUS: v[`SCAN_MSB:0] = y.scan_state;
            default: v = `BYTE_ZERO;
        endcase
        return v;
    endfunction : read_byte

    assign port_enable_rise = port_enable & ~state_ff.port_en_d[0];
    assign port_steady = clk_en && port_enable && state_ff.port_en_d[0];
    assign status_read = clk_en && rd_hit(req, `ADDR_SYS_STATUS);
    assign commit_write = clk_en && wr_hit(req, `ADDR_SYS_CTRL) && req.wdata[`BIT_COMMIT];
    assign key_live = {sys.nvm_key, sys.erase_key};
    assign key_over = {sys.nvm_done, sys.erase_done};

    // One flag each for the nvm and erase keys: a live key shows until its sequence is done [RULE1] [RULE2]
    for (genvar g = 0; g < `KEY_COUNT; g++) begin : g_key_flag
        assign key_flag_nxt[g] = key_live[g] & ~key_over[g];
    end

    always_comb begin
        nxt_state = state_ff;
        rd_mux = read_byte(req.addr, state_ff, sys);
        nxt_state.rvalid = 1'b0;
        nxt_state.urow_commit = 1'b0;
        nxt_state.port_en_d = {state_ff.port_en_d[0], port_enable};
        // Key flags follow keys, drop on done [RULE1] [RULE2]
        nxt_state.nvm_key_flag = key_flag_nxt[`KEY_NVM_SLOT];
        nxt_state.erase_key_flag = key_flag_nxt[`KEY_ERASE_SLOT];
        if (req.rd) begin // [RULE20]
            nxt_state.rdata = rd_mux; // [RULE5] [RULE15] [RULE16] [RULE17] [RULE18] [RULE19]
            nxt_state.rvalid = 1'b1;
            if (req.addr == `ADDR_SYS_STATUS) begin
                nxt_state.rst_seen = 1'b0; // [RULE14]
            end
        end
        // Held request feeds reset active; set wins over clear on read [RULE14]
        if (sys.sys_in_reset || state_ff.sys_reset_req) begin
            nxt_state.rst_seen = 1'b1;
        end
        if (req.wr) begin
            case (req.addr)
                `ADDR_RESET_REQ: begin
                    nxt_state.sys_reset_req = (req.wdata == `RESET_SIGNATURE); // [RULE3] [RULE4]
                end
                `ADDR_CLK_CTRL: begin
                    nxt_state.clk_sel = clk_sel_e'(req.wdata[`CLKSEL_MSB:0]); // [RULE7]
                end
                `ADDR_SYS_CTRL: begin
                    nxt_state.clk_request = req.wdata[`BIT_SYSTEM_CLOCK_REQUEST]; // [RULE12]
                    // Commit pulse only with key; data readiness is not checked [RULE10] [RULE11]
                    nxt_state.urow_commit = req.wdata[`BIT_COMMIT] & sys.urow_key; // [RULE9]
                end
                default: nxt_state.urow_commit = 1'b0; // [RULE21]
            endcase
        end
        if (!port_enable) begin
            nxt_state.clk_request = 1'b0; // [RULE13]
            nxt_state.clk_sel = CLK_4MHZ;
        end else if (port_enable_rise) begin
            nxt_state.clk_request = 1'b1; // [RULE13]
            nxt_state.clk_sel = CLK_4MHZ; // [RULE7]
        end
    end

    // Only the port reset clears this bank, never the request it issues [RULE6]
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= BANK_RESET;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    assign rdata = state_ff.rdata;
    assign rvalid = state_ff.rvalid;
    assign sys_reset_req = state_ff.sys_reset_req;
    assign clk_request = state_ff.clk_request;
    assign urow_commit = state_ff.urow_commit;
    assign clk_sel = state_ff.clk_sel;

    sequence sig_write;
        clk_en && req.wr && req.addr == `ADDR_RESET_REQ && req.wdata == `RESET_SIGNATURE;
    endsequence
    sequence other_write;
        clk_en && req.wr && req.addr == `ADDR_RESET_REQ && req.wdata != `RESET_SIGNATURE;
    endsequence

    AST_RESET_SET: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
        sig_write |=> sys_reset_req)
        else $error("signature write did not assert system reset");
    AST_RESET_CLR: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
        other_write |=> !sys_reset_req)
        else $error("other write did not release system reset");
    AST_RESET_HOLD: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
        sys_reset_req && !(clk_en && req.wr && req.addr == `ADDR_RESET_REQ) |=> sys_reset_req)
        else $error("system reset dropped without a write");
    AST_RESET_READ: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
        clk_en && req.rd && req.addr == `ADDR_RESET_REQ |=>
            rvalid && rdata == {7'h00, $past(sys_reset_req)})
        else $error("reset request read value wrong");
    AST_CLKSEL_WRITE: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
        clk_en && port_enable && state_ff.port_en_d[0] && req.wr && req.addr == `ADDR_CLK_CTRL
            |=> clk_sel == $past(req.wdata[1:0]))
        else $error("clock select not stored");
    AST_SYSTEM_CLOCK_REQUEST_OFF: assert property (@(posedge clk) disable iff (!resetn) // [RULE13]
        clk_en && !port_enable |=> !clk_request)
        else $error("clock request stays while port disabled");
    AST_SYSTEM_CLOCK_REQUEST_ON: assert property (@(posedge clk) disable iff (!resetn) // [RULE13]
        clk_en && port_enable_rise |=> clk_request && clk_sel == CLK_4MHZ)
        else $error("clock request not set on enable");
    AST_COMMIT_KEY: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
        clk_en && !sys.urow_key |=> !urow_commit)
        else $error("commit issued without user row key");
    AST_RST_ACTIVE: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
        clk_en && sys_reset_req |=> state_ff.rst_seen)
        else $error("reset active flag not set by held reset");
    AST_KEY_DONE: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
        clk_en && sys.nvm_done |=> !state_ff.nvm_key_flag)
        else $error("nvm key flag not cleared when done");

    sequence key_write;
        commit_write && sys.urow_key;
    endsequence

    sequence system_clock_request_write;
        port_steady && wr_hit(req, `ADDR_SYS_CTRL);
    endsequence

    sequence quiet_status_read;
        status_read && !sys.sys_in_reset && !sys_reset_req;
    endsequence

    sequence sig_then_other;
        sig_write ##[1:8] other_write;
    endsequence

    AST_COMMIT_START: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
        key_write
        |=> urow_commit)
        else $error("keyed commit write did not start programming");

    AST_COMMIT_PULSE: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
        clk_en && urow_commit && !commit_write
        |=> !urow_commit)
        else $error("commit pulse lasted more than one cycle");

    AST_KEY_NVM_SET: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
        clk_en && sys.nvm_key && !sys.nvm_done
        |=> state_ff.nvm_key_flag)
        else $error("nvm key flag not set while key active");

    AST_KEY_ERASE_SET: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
        clk_en && sys.erase_key && !sys.erase_done
        |=> state_ff.erase_key_flag)
        else $error("erase key flag not set while key active");

    AST_KEY_ERASE_DONE: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
        clk_en && sys.erase_done
        |=> !state_ff.erase_key_flag)
        else $error("erase key flag not cleared when done");

    AST_KEY_IDLE: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
        clk_en && !sys.nvm_key
        |=> !state_ff.nvm_key_flag)
        else $error("nvm key flag set without key");

    AST_KEY_ERASE_IDLE: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
        clk_en && !sys.erase_key
        |=> !state_ff.erase_key_flag)
        else $error("erase key flag set without key");

    AST_KEY_READ: assert property (@(posedge clk) disable iff (!resetn) // [RULE1] [RULE2]
        clk_en && rd_hit(req, `ADDR_KEY_STATUS)
        |=> rdata == {2'b00, $past(sys.urow_key), $past(state_ff.nvm_key_flag),
            $past(state_ff.erase_key_flag), 3'b000})
        else $error("key status read value wrong");

    AST_RESET_CYCLE: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
        sig_then_other
        |=> !sys_reset_req)
        else $error("held reset not released by later write");

    AST_RESET_OWN: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
        port_steady && wr_hit(req, `ADDR_RESET_REQ)
        |=> $stable(clk_sel) && $stable(clk_request))
        else $error("reset request disturbed port settings");

    AST_CLKSEL_OFF: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
        clk_en && !port_enable
        |=> clk_sel == CLK_4MHZ)
        else $error("clock select not default while port disabled");

    AST_CLKSEL_READ: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
        clk_en && rd_hit(req, `ADDR_CLK_CTRL)
        |=> rdata == {6'h00, $past(clk_sel)})
        else $error("clock select read value wrong");

    AST_SYSTEM_CLOCK_REQUEST_WRITE: assert property (@(posedge clk) disable iff (!resetn) // [RULE12]
        system_clock_request_write
        |=> clk_request == $past(req.wdata[`BIT_SYSTEM_CLOCK_REQUEST]))
        else $error("clock request not stored");

    AST_SYSTEM_CLOCK_REQUEST_KEEP: assert property (@(posedge clk) disable iff (!resetn) // [RULE12]
        port_steady && !wr_hit(req, `ADDR_SYS_CTRL)
        |=> $stable(clk_request))
        else $error("clock request changed without a write");

    AST_RST_ACTIVE_SYS: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
        clk_en && sys.sys_in_reset
        |=> state_ff.rst_seen)
        else $error("reset active flag not set by system reset");

    AST_RST_ACTIVE_CLR: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
        quiet_status_read
        |=> !state_ff.rst_seen)
        else $error("reset active flag not cleared by read");

    AST_RST_ACTIVE_KEEP: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
        clk_en && state_ff.rst_seen && !status_read
        |=> state_ff.rst_seen)
        else $error("reset active flag lost without a read");

    AST_STATUS_READ: assert property (@(posedge clk) disable iff (!resetn) // [RULE15] [RULE18]
        status_read
        |=> rdata == {2'b00, $past(state_ff.rst_seen), $past(sys.sys_asleep),
            $past(sys.prog_ready), $past(sys.urow_ready), 1'b0,
            $past(sys.locked)})
        else $error("system status read value wrong");

    AST_SCAN_READ: assert property (@(posedge clk) disable iff (!resetn) // [RULE19]
        clk_en && rd_hit(req, `ADDR_SCAN_STATUS)
        |=> rdata == {5'h00, $past(sys.scan_state)})
        else $error("scan status read value wrong");

    AST_CTRL_READ: assert property (@(posedge clk) disable iff (!resetn) // [RULE21]
        clk_en && rd_hit(req, `ADDR_SYS_CTRL)
        |=> rdata == {6'h00, $past(urow_commit), $past(clk_request)})
        else $error("system control read value wrong");

    AST_UNUSED_READ: assert property (@(posedge clk) disable iff (!resetn) // [RULE21]
        clk_en && req.rd && (req.addr < `ADDR_KEY_STATUS || req.addr > `ADDR_SCAN_STATUS)
        |=> rdata == `BYTE_ZERO)
        else $error("unused address read not zero");

    AST_RVALID_ON: assert property (@(posedge clk) disable iff (!resetn) // [RULE20]
        clk_en && req.rd
        |=> rvalid)
        else $error("read not answered with valid");

    AST_RVALID_OFF: assert property (@(posedge clk) disable iff (!resetn) // [RULE20]
        clk_en && !req.rd
        |=> !rvalid)
        else $error("valid without a read");

    AST_FREEZE: assert property (@(posedge clk) disable iff (!resetn)
        !clk_en
        |=> $stable(state_ff))
        else $error("state changed while clock enable low");
endmodule : prog_debug_access_regs

// ---- test/debug_host_model.sv ----
// Debugger model issuing single byte access layer requests
`timescale 1ns/1ps
module debug_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    output prog_debug_pkg::reg_req_s req
);
    import prog_debug_pkg::*;
    initial req = '0;
    // One write, held until its taking edge; clock enable and clock select are left to the caller
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) req <= '0;
    endtask : wr
    // One read, data taken with the valid pulse
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk) req <= '0;
        #1 d = rvalid ? rdata : 8'hxx;
    endtask : rd
endmodule : debug_host_model

// ---- test/prog_debug_access_regs_bench.sv ----
// Self-checking bench of the access layer register bank
`timescale 1ns/1ps
module prog_debug_access_regs_bench;
    import prog_debug_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic port_enable = 1'b1;
    logic clk_en = 1'b1;
    sys_state_s sys = '{locked: 1'b1, default: '0};
    reg_req_s req;
    logic [7:0] rdata;
    logic [7:0] v;
    logic rvalid, sys_reset_req, clk_request, urow_commit;
    clk_sel_e clk_sel;
    int miscompares = 0;
    int check_count = 0;
    row_s rows [11] = '{
        '{8'h08, 8'h59, 8'h01},
        '{8'h08, 8'h12, 8'h00},
        '{8'h09, 8'h01, 8'h01},
        '{8'h09, 8'h02, 8'h02},
        '{8'h09, 8'h00, 8'h00},
        '{8'h09, 8'h03, 8'h03},
        '{8'h0a, 8'h01, 8'h01},
        '{8'h0a, 8'h00, 8'h00},
        '{8'h0a, 8'hfc, 8'h00},
        '{8'h0c, 8'hff, 8'h00},
        '{8'h0d, 8'hff, 8'h00}};
    prog_debug_access_regs dut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
        .port_enable(port_enable), .req(req), .sys(sys), .rdata(rdata), .rvalid(rvalid),
        .sys_reset_req(sys_reset_req), .clk_request(clk_request),
        .urow_commit(urow_commit), .clk_sel(clk_sel));
    debug_host_model host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic test_done;
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    initial forever #20 clk = ~clk;
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk) #1 chk("clk_request", 8'h01, {7'h0, clk_request});
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].d);
            host.rd(rows[i].a, v);
            chk("row", rows[i].e, v);
        end
        host.wr(8'h09, 8'h01);
        host.wr(8'h08, 8'h59);
        #1 chk("sys_reset_req", 8'h01, {7'h0, sys_reset_req});
        chk("clk_sel", 8'h01, {6'h0, clk_sel});
        host.rd(8'h0b, v);
        chk("status", 8'h21, v);
        host.wr(8'h08, 8'h00);
        host.rd(8'h0b, v);
        chk("status", 8'h21, v);
        host.rd(8'h0b, v);
        chk("status", 8'h01, v);
        @(posedge clk) sys <= '{sys_asleep: 1'b1, prog_ready: 1'b1, urow_ready: 1'b1, default: '0};
        host.rd(8'h0b, v);
        chk("status", 8'h1c, v);
        host.wr(8'h0a, 8'h02);
        #1 chk("urow_commit", 8'h00, {7'h0, urow_commit});
        @(posedge clk) sys.urow_key <= 1'b1;
        host.wr(8'h0a, 8'h02);
        #1 chk("urow_commit", 8'h01, {7'h0, urow_commit});
        foreach (rows[k]) begin
            @(posedge clk) sys.scan_state <= 3'(k < 3 ? k : 4) & 3'h7;
            host.rd(8'h0c, v);
            chk("scan", {5'h0, 3'(k < 3 ? k : 4)}, v);
            if (k == 3)
                break;
        end
        @(posedge clk) sys <= '{nvm_key: 1'b1, erase_key: 1'b1, default: '0};
        host.rd(8'h07, v);
        chk("keys", 8'h18, v);
        @(posedge clk) sys.nvm_done <= 1'b1;
        sys.erase_done <= 1'b1;
        host.rd(8'h07, v);
        chk("keys", 8'h00, v);
        @(posedge clk) sys <= '{sys_in_reset: 1'b1, default: '0};
        host.rd(8'h0b, v);
        chk("status", 8'h20, v);
        @(posedge clk) sys.sys_in_reset <= 1'b0;
        @(posedge clk) port_enable <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("clk_request", 8'h00, {7'h0, clk_request});
        chk("clk_sel", 8'h03, {6'h0, clk_sel});
        @(posedge clk) port_enable <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("clk_request", 8'h01, {7'h0, clk_request});
        @(posedge clk) clk_en <= 1'b0;
        host.wr(8'h09, 8'h01);
        #1 chk("clk_sel", 8'h03, {6'h0, clk_sel});
        @(posedge clk) clk_en <= 1'b1;
        host.wr(8'h08, 8'h59);
        @(posedge clk) resetn <= 1'b0;
        @(posedge clk) #1 chk("sys_reset_req", 8'h00, {7'h0, sys_reset_req});
        @(posedge clk) resetn <= 1'b1;
        host.rd(8'h08, v);
        chk("reset_req", 8'h00, v);
        host.rd(8'h0a, v);
        chk("sys_ctrl", 8'h01, v);
        test_done();
    end
endmodule : prog_debug_access_regs_bench
